// File: bench/mdio_host.sv
// Station controller model driving MDC/MDIO frames into the bank.
// Assumes a free-running clk_sys and a pull-up on the mdio wire.
`timescale 1ns/10ps
`default_nettype none
module mdio_host (
   input wire logic clk_sys, // System clock
   output logic mdc, // Management clock
   output logic mdio_i, // Resolved wire level
   input wire logic mdio_o, // Bank data
   input wire logic mdio_oe // Bank drive enable
);
   logic drv = 1'h1;
   initial mdc = 1'h0;
   assign mdio_i = mdio_oe ? mdio_o : drv; // Released wire reads pull-up
   // Read sampled half a clk after the rise, when the bank's bit has settled
   task automatic bit_cyc(input logic b, output logic s);
      @(posedge clk_sys);
      drv <= b;
      mdc <= 1'h0;
      repeat (3) @(posedge clk_sys);
      mdc <= 1'h1;
      // Mid-cycle sample: the bank may release the wire on the next edge
      @(negedge clk_sys);
      s = mdio_i;
      repeat (4) @(posedge clk_sys);
   endtask
   // Fresh preamble each frame; mdc rests high between frames
   task automatic xfer(input logic [1:0] op, input logic [4:0] phy, ra,
         input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] f;
      logic s;
      f = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
      for (int i = 63; i >= 0; i--) begin
         bit_cyc((op == 2'h2 && i < 18) ? 1'h1 : f[i], s);
         if (i < 16) rd[i] = s;
      end
   endtask
endmodule
`default_nettype wire

// File: bench/phy_mgmt_status_regs_asserts.sv
// Port-level checks of the management register bank.
// Assumes mdc halves last at least two clk_sys cycles.
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_status_regs_asserts (
   input wire logic clk_sys, // System clock
   input wire logic sys_rst, // Async reset
   input wire logic mdc, // Management clock
   input wire logic mdio_i, // Data in
   input wire logic mdio_o, // Data out
   input wire logic mdio_oe, // Drive enable
   input wire phy_mgmt_pkg::port_status_t [1:0] port_st, // Port status
   input wire phy_mgmt_pkg::cable_result_t cable_res, // Test outcome
   input wire logic [1:0][4:0] adv_abil, // Advertised
   input wire logic [1:0] force_link, // Force link
   input wire logic cable_start, // Start pulse
   input wire logic cable_busy // Test running
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   reset_defaults_a: assert property ($fell(sys_rst) |-> adv_abil == 10'h3FF &&
      force_link == 2'h0 && !cable_busy) else $error("defaults wrong after reset");
   start_pulse_a: assert property (cable_start |=> !cable_start)
      else $error("start pulse longer than one cycle");
   start_busy_a: assert property (cable_start |-> cable_busy)
      else $error("start without busy");
   busy_cause_a: assert property ($rose(cable_busy) |-> cable_start)
      else $error("busy rose without start");
   busy_hold_a: assert property (cable_busy && !cable_res.done |=> cable_busy)
      else $error("busy dropped before test done");
   busy_clear_a: assert property (cable_busy && cable_res.done |->
      ##[1:2] (!cable_busy || cable_start)) else $error("busy not cleared after done");
   oe_after_fall_a: assert property ($rose(mdio_oe) |-> !$past(mdc))
      else $error("drive began outside mdc low");
   data_after_fall_a: assert property (mdio_oe && $changed(mdio_o) |-> !$past(mdc))
      else $error("read bit changed outside mdc low");
   oe_release_a: assert property ($fell(mdio_oe) |-> $past(mdc))
      else $error("drive released outside mdc high");
   reg_commit_a: assert property ($changed(adv_abil) || $changed(force_link) |->
      $past(mdc)) else $error("control bits changed outside a commit");
   cover property (cable_start);
   cover property ($rose(mdio_oe));
   cover property ($changed(force_link));
endmodule
bind phy_mgmt_status_regs phy_mgmt_status_regs_asserts u_chk (.clk_sys, .sys_rst, .mdc,
   .mdio_i, .mdio_o, .mdio_oe, .port_st, .cable_res, .adv_abil, .force_link, .cable_start,
   .cable_busy);
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the management register bank.
// Assumes the host model owns mdc/mdio; the bench plays the switch side.
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk_sys = 1'h0;
   logic sys_rst = 1'h1;
   phy_mgmt_pkg::port_status_t [1:0] port_st = '0;
   phy_mgmt_pkg::cable_result_t cable_res = '0;
   logic mdc, mdio_i, mdio_o, mdio_oe, cable_start, cable_busy;
   logic [1:0][4:0] adv_abil;
   logic [1:0] force_link;
   logic [15:0] rd, ct;
   int error_cnt = 0;
   int n_tests = 0;
   always #50 clk_sys = ~clk_sys;
   phy_mgmt_status_regs #(.IDENT_UPPER(16'h1234), .IDENT_LOWER(16'h5670)) dut (.clk_sys,
      .sys_rst, .mdc, .mdio_i, .mdio_o, .mdio_oe, .port_st, .cable_res, .adv_abil,
      .force_link, .cable_start, .cable_busy);
   mdio_host host (.clk_sys, .mdc, .mdio_i, .mdio_o, .mdio_oe);
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rchk(input logic [4:0] phy, ra, input logic [15:0] exp);
      host.xfer(2'h2, phy, ra, 16'h0000, rd);
      chk($sformatf("phy %0d reg %h", phy, ra), exp, rd);
   endtask
   task automatic wr(input logic [4:0] phy, ra, input logic [15:0] wd);
      host.xfer(2'h1, phy, ra, wd, rd);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'h0;
      rchk(5'h01, 5'h02, 16'h1234);
      rchk(5'h02, 5'h03, 16'h5670);
      rchk(5'h01, 5'h04, 16'h05E1);
      port_st[0].link_up <= 1'h1;
      rchk(5'h01, 5'h01, 16'h780C);
      port_st[0] <= 9'h080;
      port_st[1].partner <= 5'h15;
      rchk(5'h01, 5'h01, 16'h7828);
      rchk(5'h02, 5'h05, 16'h04A0);
      wr(5'h01, 5'h04, 16'hFC5E);
      rchk(5'h01, 5'h04, 16'h0441);
      wr(5'h02, 5'h04, 16'h0000);
      rchk(5'h02, 5'h04, 16'h0001);
      chk("adv_abil", 16'h0012, {6'h00, adv_abil});
      port_st[0].pol_rev <= 1'h1;
      port_st[1].mdix <= 1'h1;
      wr(5'h01, 5'h1F, 16'hFFFF);
      rchk(5'h01, 5'h1F, 16'h0028);
      rchk(5'h02, 5'h1F, 16'h0010);
      chk("force_link", 16'h0001, {14'h0000, force_link});
      rchk(5'h03, 5'h02, 16'hFFFF);
      wr(5'h01, 5'h1D, 16'h8000);
      chk("cable_busy", 16'h0000, {15'h0000, cable_busy});
      rchk(5'h01, 5'h1D, 16'h0000);
      ct = 16'h0000;
      for (int r = 0; r < 4; r++) begin
         wr(5'h02, 5'h1D, 16'h8000);
         chk("cable_busy", 16'h0001, {15'h0000, cable_busy});
         rchk(5'h02, 5'h1D, ct | 16'h8000);
         @(posedge clk_sys);
         cable_res <= {1'h1, 2'(r), r[0], 2'(r), 7'h2B};
         @(posedge clk_sys);
         cable_res.done <= 1'h0;
         ct = {1'h0, 2'(r), r[0], 3'h0, 2'(r), 7'h2B};
         // Host must see the start bit clear before trusting results
         for (int k = 0; k < 8; k++) begin
            host.xfer(2'h2, 5'h02, 5'h1D, 16'h0000, rd);
            if (rd[15] === 1'h0) break;
         end
         chk("cable test completion", 16'h0000, {15'h0000, rd[15]});
         if (rd[15] !== 1'h0) break;
         chk("cable result", ct, rd);
      end
      results();
   end
endmodule
`default_nettype wire

// File: hdl/phy_mgmt_defines.svh
// Constants for the two-port management register bank.
// Assumes the management clock is sampled on clk_sys.
`ifndef PHY_MGMT_DEFINES_SVH
`define PHY_MGMT_DEFINES_SVH
`define PHYSEL_PORT1 5'h01
`define PHYSEL_PORT2 5'h02
`define REG_BASIC_STATUS 5'h01
`define REG_IDENT_HIGH 5'h02
`define REG_IDENT_LOW 5'h03
`define REG_AUTONEG_ADV 5'h04
`define REG_PARTNER_ABIL 5'h05
`define REG_CABLE_DIAG 5'h1D
`define REG_SPECIAL 5'h1F
`define BASIC_STATUS_FIXED 16'h7808
`define BIT_LINK 2
`define BIT_AN_DONE 5
`define SELECTOR_8023 5'h01
`define SELECTOR_LSB 0
`define ADV_LSB 5
`define ABIL_W 4
`define BIT_PAUSE 10
`define ADV_RESET 5'h1F
`define FORCE_LINK_RESET 1'h0
`define BIT_FORCE_LINK 3
`define BIT_MDIX 4
`define BIT_POLARITY 5
`define BIT_CT_START 15
`define CT_RESULT_LSB 13
`define BIT_CT_SHORT 12
`define CT_COUNT_LSB 0
`define TA_LAST 4'h1
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define PREAMBLE_ONES 6'h20
`define HDR_LAST 4'hB
`define DATA_LAST 4'hF
`endif

// File: hdl/phy_mgmt_pkg.sv
// Types for the two-port management register bank.
// Assumes the defines header is compiled alongside.
package phy_mgmt_pkg;
   // Live status taken from one switch port
   typedef struct packed {
      logic link_up;
      logic an_done;
      logic [4:0] partner;
      logic pol_rev;
      logic mdix;
   } port_status_t;
   // Outcome of one cable test on the second port
   typedef struct packed {
      logic done;
      logic [1:0] result;
      logic near_short_flag;
      logic [8:0] count;
   } cable_result_t;
   typedef enum logic [2:0] {
      S_PRE,
      S_ST,
      S_HDR,
      S_TA,
      S_RD,
      S_WR
   } mgmt_state_t;
   typedef struct packed {
      mgmt_state_t st;
      logic mdc_prev;
      logic [5:0] ones;
      logic [3:0] cnt;
      logic [11:0] hdr;
      logic [15:0] sh;
      logic rd;
      logic mdio_o;
      logic mdio_oe;
      logic [1:0][4:0] adv;
      logic [1:0] force_link;
      logic ct_run;
      logic ct_start;
      logic [1:0] ct_res;
      logic ct_short;
      logic [8:0] ct_count;
   } bank_state_t;
endpackage

// File: hdl/phy_mgmt_status_regs.sv
// Management register bank for two copper ports, reached over MDC/MDIO.
// Assumes mdc and mdio_i are synchronous to clk_sys and far slower.
// Port status comes live from the switch port registers.
`timescale 1ns/10ps
`default_nettype none
`include "phy_mgmt_defines.svh"

module phy_mgmt_status_regs #(
   parameter logic [15:0] IDENT_UPPER = 16'hA5A5, // Arbitrary value
   parameter logic [15:0] IDENT_LOWER = 16'h5A50  // Arbitrary value
) (
   input wire logic clk_sys, // System clock
   input wire logic sys_rst, // Async reset, high
   input wire logic mdc, // Management clock, sampled
   input wire logic mdio_i, // Management data in
   output logic mdio_o, // Management data out
   output logic mdio_oe, // High while driving mdio
   input wire phy_mgmt_pkg::port_status_t [1:0] port_st, // Port status
   input wire phy_mgmt_pkg::cable_result_t cable_res, // Test outcome
   output logic [1:0][4:0] adv_abil, // Advertised abilities
   output logic [1:0] force_link, // Force link pass
   output logic cable_start, // One-cycle test start
   output logic cable_busy // Test in progress
);

   phy_mgmt_pkg::bank_state_t s_q;
   phy_mgmt_pkg::bank_state_t s_d;

   // Edges of the sampled management clock
   logic rise;
   logic fall;

   // Header fields once the whole header is in
   logic [4:0] hdr_phy;
   logic [4:0] hdr_reg;
   logic [1:0] hdr_op;
   logic [1:0] port_hit;
   logic port_ok;
   logic port_idx;

   // Header fields one bit before the header is complete
   logic [4:0] pend_phy;
   logic [1:0] pend_op;
   logic pend_ours;
   logic pend_rd;
   logic pend_wr;

   // Frame position
   logic pre_full;
   logic hdr_end;
   logic ta_end;
   logic data_end;
   logic ta_drive;
   logic [15:0] rdata;
   logic [15:0] wdata;

   // Per-port read images, index 0 at address 1, index 1 at address 2
   logic [1:0][15:0] stat_word;
   logic [1:0][15:0] adv_word;
   logic [1:0][15:0] part_word;
   logic [1:0][15:0] spec_word;
   logic [15:0] diag_word;

   // Write strobes, valid only on the rise that samples data bit 0
   logic commit;
   logic adv_wr;
   logic spec_wr;
   logic diag_wr;
   logic [4:0] adv_new;
   logic [1:0][4:0] adv_nxt;
   logic [1:0] force_nxt;

   assign rise = mdc & ~s_q.mdc_prev;
   assign fall = ~mdc & s_q.mdc_prev;
   // Header as shifted: op in top bits, then phy, then reg
   assign hdr_op = s_q.hdr[11:10];
   assign hdr_phy = s_q.hdr[9:5];
   assign hdr_reg = s_q.hdr[4:0];
   assign port_ok = |port_hit;
   assign port_idx = port_hit[1];
   assign wdata = {s_q.sh[14:0], mdio_i};

   // The last header bit is still on the wire when these are decoded
   assign pend_op = s_q.hdr[10:9];
   assign pend_phy = s_q.hdr[8:4];
   assign pend_ours = (pend_phy == `PHYSEL_PORT1) || (pend_phy == `PHYSEL_PORT2);
   assign pend_rd = pend_ours && (pend_op == `OP_READ);
   assign pend_wr = pend_ours && (pend_op == `OP_WRITE);

   assign pre_full = (s_q.ones == `PREAMBLE_ONES);
   assign hdr_end = (s_q.cnt == `HDR_LAST);
   assign ta_end = (s_q.cnt == `TA_LAST);
   assign data_end = (s_q.cnt == `DATA_LAST);
   // Take the wire after the first turnaround bit, so the host has let go
   assign ta_drive = (s_q.st == phy_mgmt_pkg::S_TA) && s_q.rd && ta_end;

   // Commit only for a whole write frame to one of our two ports
   // Opcode rechecked so a stale read flag can never commit
   assign commit = rise && (s_q.st == phy_mgmt_pkg::S_WR) && data_end && port_ok &&
      (hdr_op == `OP_WRITE);
   assign adv_wr = commit && (hdr_reg == `REG_AUTONEG_ADV);
   assign spec_wr = commit && (hdr_reg == `REG_SPECIAL);
   // Address 1 has no diagnostics; a start written there is dropped
   assign diag_wr = commit && (hdr_reg == `REG_CABLE_DIAG) && port_idx &&
      wdata[`BIT_CT_START];
   // Bit 9 is reserved and not stored
   assign adv_new = {wdata[`BIT_PAUSE], wdata[`ADV_LSB+:`ABIL_W]};

   for (genvar p = 0; p < 2; p++) begin : g_port
      assign port_hit[p] = (hdr_phy == (`PHYSEL_PORT1 + 5'(p)));

      // Read images built from live status and stored fields
      always_comb begin
         stat_word[p] = `BASIC_STATUS_FIXED;
         stat_word[p][`BIT_LINK] = port_st[p].link_up;
         stat_word[p][`BIT_AN_DONE] = port_st[p].an_done;
         // Reserved bits, next page and remote fault read zero
         adv_word[p] = 16'h0000;
         adv_word[p][`SELECTOR_LSB+:5] = `SELECTOR_8023;
         adv_word[p][`BIT_PAUSE] = s_q.adv[p][`ABIL_W];
         adv_word[p][`ADV_LSB+:`ABIL_W] = s_q.adv[p][`ABIL_W-1:0];
         part_word[p] = 16'h0000;
         part_word[p][`BIT_PAUSE] = port_st[p].partner[`ABIL_W];
         part_word[p][`ADV_LSB+:`ABIL_W] = port_st[p].partner[`ABIL_W-1:0];
         spec_word[p] = 16'h0000;
         spec_word[p][`BIT_POLARITY] = port_st[p].pol_rev;
         spec_word[p][`BIT_MDIX] = port_st[p].mdix;
         spec_word[p][`BIT_FORCE_LINK] = s_q.force_link[p];
      end

      // Next value of this port's writable fields
      always_comb begin
         adv_nxt[p] = s_q.adv[p];
         force_nxt[p] = s_q.force_link[p];
         if (adv_wr && port_hit[p]) begin
            adv_nxt[p] = adv_new;
         end
         if (spec_wr && port_hit[p]) begin
            force_nxt[p] = wdata[`BIT_FORCE_LINK];
         end
      end
   end

   // Diagnostics image; results keep the last test until the next ends
   always_comb begin
      diag_word = 16'h0000;
      diag_word[`BIT_CT_START] = s_q.ct_run;
      diag_word[`CT_RESULT_LSB+:2] = s_q.ct_res;
      diag_word[`BIT_CT_SHORT] = s_q.ct_short;
      diag_word[`CT_COUNT_LSB+:9] = s_q.ct_count;
   end

   // Read word for the addressed register
   always_comb begin
      rdata = 16'h0000;
      case (hdr_reg)
         `REG_BASIC_STATUS: begin
            rdata = stat_word[port_idx];
         end

         `REG_IDENT_HIGH: begin
            rdata = IDENT_UPPER;
         end

         `REG_IDENT_LOW: begin
            rdata = IDENT_LOWER;
         end

         `REG_AUTONEG_ADV: begin
            rdata = adv_word[port_idx];
         end

         `REG_PARTNER_ABIL: begin
            rdata = part_word[port_idx];
         end

         `REG_CABLE_DIAG: begin
            if (port_idx) begin
               rdata = diag_word;
            end
         end

         `REG_SPECIAL: begin
            rdata = spec_word[port_idx];
         end

         default: begin
            rdata = 16'h0000;
         end
      endcase
   end

   // Frame engine and register updates
   always_comb begin
      s_d = s_q;
      s_d.mdc_prev = mdc;
      s_d.ct_start = 1'b0;

      // Test completion clears the start bit; results then valid
      if (cable_res.done && s_q.ct_run) begin
         s_d.ct_run = 1'b0;
         s_d.ct_res = cable_res.result;
         s_d.ct_short = cable_res.near_short_flag;
         s_d.ct_count = cable_res.count;
      end

      if (rise) begin
         case (s_q.st)
            phy_mgmt_pkg::S_PRE: begin
               // Ones are counted across idle, so a short gap still counts
               if (mdio_i) begin
                  if (!pre_full) begin
                     s_d.ones = s_q.ones + 6'h01;
                  end
               end else if (pre_full) begin
                  s_d.st = phy_mgmt_pkg::S_ST;
               end else begin
                  s_d.ones = 6'h00;
               end
            end

            phy_mgmt_pkg::S_ST: begin
               s_d.ones = 6'h00;
               s_d.cnt = 4'h0;
               // Second start bit must be one
               if (mdio_i) begin
                  s_d.st = phy_mgmt_pkg::S_HDR;
               end else begin
                  s_d.st = phy_mgmt_pkg::S_PRE;
               end
            end

            phy_mgmt_pkg::S_HDR: begin
               s_d.hdr = {s_q.hdr[10:0], mdio_i};
               s_d.cnt = s_q.cnt + 4'h1;
               if (hdr_end) begin
                  s_d.cnt = 4'h0;
                  // Foreign addresses and bad opcodes drop the frame
                  if (pend_rd) begin
                     s_d.st = phy_mgmt_pkg::S_TA;
                     s_d.rd = 1'b1;
                  end else if (pend_wr) begin
                     s_d.st = phy_mgmt_pkg::S_TA;
                     s_d.rd = 1'b0;
                  end else begin
                     s_d.st = phy_mgmt_pkg::S_PRE;
                  end
               end
            end

            phy_mgmt_pkg::S_TA: begin
               s_d.cnt = s_q.cnt + 4'h1;
               if (ta_end) begin
                  s_d.cnt = 4'h0;
                  // One capture, so a read sees a coherent status snapshot
                  s_d.sh = rdata;
                  if (s_q.rd) begin
                     s_d.st = phy_mgmt_pkg::S_RD;
                  end else begin
                     s_d.st = phy_mgmt_pkg::S_WR;
                  end
               end
            end

            phy_mgmt_pkg::S_RD: begin
               s_d.cnt = s_q.cnt + 4'h1;
               // Wire released right after the rise that samples bit 0
               if (data_end) begin
                  s_d.cnt = 4'h0;
                  s_d.mdio_oe = 1'b0;
                  s_d.st = phy_mgmt_pkg::S_PRE;
               end
            end

            phy_mgmt_pkg::S_WR: begin
               // Shift keeps 15 bits; wdata adds the bit on the wire
               s_d.sh = wdata;
               s_d.cnt = s_q.cnt + 4'h1;
               if (data_end) begin
                  s_d.cnt = 4'h0;
                  s_d.st = phy_mgmt_pkg::S_PRE;
               end
            end

            default: begin
               s_d.st = phy_mgmt_pkg::S_PRE;
            end
         endcase
      end else if (fall) begin
         // Drive on the falling edge so the host samples a settled bit
         if (ta_drive) begin
            s_d.mdio_oe = 1'b1;
            s_d.mdio_o = 1'b0;
         end else if (s_q.st == phy_mgmt_pkg::S_RD) begin
            s_d.mdio_o = s_q.sh[15];
            s_d.sh = {s_q.sh[14:0], 1'b0};
         end
      end

      // Writable fields; a start beats a completion in the same cycle
      s_d.adv = adv_nxt;
      s_d.force_link = force_nxt;
      if (diag_wr) begin
         s_d.ct_run = 1'b1;
         s_d.ct_start = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s_q.st <= phy_mgmt_pkg::S_PRE;
         s_q.mdc_prev <= 1'b0;
         s_q.ones <= 6'h00;
         s_q.cnt <= 4'h0;
         s_q.hdr <= 12'h000;
         s_q.sh <= 16'h0000;
         s_q.rd <= 1'b0;
         s_q.mdio_o <= 1'b0;
         s_q.mdio_oe <= 1'b0;
         s_q.adv <= {`ADV_RESET, `ADV_RESET};
         s_q.force_link <= {`FORCE_LINK_RESET, `FORCE_LINK_RESET};
         s_q.ct_run <= 1'b0;
         s_q.ct_start <= 1'b0;
         s_q.ct_res <= 2'h0;
         s_q.ct_short <= 1'b0;
         s_q.ct_count <= 9'h000;
      end else begin
         s_q <= s_d;
      end
   end

   assign mdio_o = s_q.mdio_o;
   assign mdio_oe = s_q.mdio_oe;
   assign adv_abil = s_q.adv;
   assign force_link = s_q.force_link;
   assign cable_start = s_q.ct_start;
   assign cable_busy = s_q.ct_run;

endmodule
`default_nettype wire
